// [rtl/ramp_defs.svh]
`ifndef RAMP_DEFS_SVH
`define RAMP_DEFS_SVH

// ****************************************
// clocking and timing
// ****************************************
`define CLK_HZ             25000000
`define TICK_US            1
`define TICK_CYCLES        (`CLK_HZ / 1000000 * `TICK_US)
`define TICKS_PER_MS       (1000 / `TICK_US)

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL           8'h00
`define OFS_ASSIGN         8'h04
`define OFS_UP_TIMES       8'h08
`define OFS_DOWN_TIMES     8'h0c
`define OFS_FREQ           8'h10
`define OFS_STATUS         8'h14

// ****************************************
// control fields
// ****************************************
`define CTRL_RUN           0
`define CTRL_STOP          1
`define CTRL_PROFILE_LO    2
`define CTRL_ADAPT_LO      4
`define CTRL_STOP_TYPE_LO  6
`define CTRL_TWO_WIRE      8
`define CTRL_TRIG_LEVEL    9
`define CTRL_LOOP_START    10

// ****************************************
// assignment fields
// ****************************************
`define ASG_SWITCH_LO      0
`define ASG_COAST_LO       4
`define ASG_QUICK_LO       8
`define ASG_DIV_LO         12

// ****************************************
// reset values and limits
// ****************************************
`define RST_CTRL           32'h0000_0000
`define RST_ASSIGN         32'h0000_4000
`define RST_UP_TIMES       32'h0032_001e
`define RST_DOWN_TIMES     32'h0032_001e
`define RST_FREQ           32'h0000_01f4
`define DIV_MAX            4'ha
`define SLOPE_NOMINAL      8'h64
`define SLOPE_S_ROUND      8'ha7
`define SLOPE_U_ROUND      8'hc8

`endif

// [rtl/ramp_pkg.sv]
package ramp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_RUN       = 3'b001,
        ST_RAMP_STOP = 3'b010,
        ST_FAST_STOP = 3'b011,
        ST_COAST     = 3'b100
    } drive_state_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic [15:0] out_freq;
        logic        motor_enable;
        logic        loss_braking;
    } drive_out_s;

endpackage

// [rtl/speed_ramp_and_stop_control.sv]
`timescale 1ns/1ps
`include "ramp_defs.svh"

module speed_ramp_and_stop_control
    import ramp_pkg::*;
(
    input  wire logic             ref_clk_in,
    input  wire logic             arst_n_in,
    input  wire ramp_pkg::apb_req_s apb_req_in,
    output ramp_pkg::apb_rsp_s    apb_rsp_out,
    input  wire logic [3:0]       logic_input_in,
    input  wire logic             dc_bus_high_in,
    output ramp_pkg::drive_out_s  drive_out
);
    import ramp_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [4:0]   s1;
        logic [4:0]   s2;
        logic [4:0]   s3;
        logic [4:0]   filt;
        logic [31:0]  ctrl;
        logic [31:0]  asg;
        logic [31:0]  up_t;
        logic [31:0]  dn_t;
        logic [31:0]  fcfg;
        logic [15:0]  freq;
        logic [15:0]  start;
        logic [32:0]  err;
        logic [9:0]   tick_cnt;
        logic         tick;
        drive_state_e st;
        logic         coast_lock;
        logic         run_prev;
        apb_rsp_s     rsp;
        drive_out_s   dout;
    } core_s;

    localparam logic [9:0] TICK_LAST = 10'(`TICK_CYCLES - 1);

    core_s cur_reg;
    core_s cur_next;
    logic  rst_s1_reg;
    logic  rst_n_reg;

    // selector code 1-4 picks an input active high, 5-8 active low
    function automatic logic li_pick(input logic [3:0] sel, input logic [3:0] li);
        logic r;
        r = 1'b0;
        if (sel >= 4'h1 && sel <= 4'h4) begin
            r = li[2'(sel - 4'h1)];
        end else if (sel >= 4'h5 && sel <= 4'h8) begin
            r = ~li[2'(sel - 4'h5)];
        end
        return r;
    endfunction

    // trigger field 0 is unassigned, 1-4 picks an input that acts when low
    function automatic logic low_pick(input logic [2:0] sel, input logic [3:0] li);
        logic r;
        r = 1'b0;
        if (sel != 3'h0 && sel <= 3'h4) begin
            r = ~li[2'(sel - 3'h1)];
        end
        return r;
    endfunction

    // ****************************************
    // reset release
    // ****************************************
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    logic [3:0]  li;
    logic        dc_high;
    logic        run_cmd;
    logic        sw_act;
    logic        coast_trig;
    logic        quick_trig;
    logic        stop_req;
    logic [1:0]  profile;
    logic [1:0]  adapt;
    logic [1:0]  stop_type;
    logic [3:0]  div;
    logic [15:0] target;
    logic [15:0] rated;
    logic [15:0] ramp_time;
    logic [15:0] span;
    logic [15:0] prog;
    logic [7:0]  slope;
    logic [31:0] thr;
    logic [32:0] sum;
    logic        accel;
    logic        hold;

    always_comb begin
        cur_next = cur_reg;
        li       = cur_reg.filt[3:0];
        dc_high  = cur_reg.filt[4];

        // pin inputs: a change counts once the second and third stages agree
        cur_next.s1 = {dc_bus_high_in, logic_input_in};
        cur_next.s2 = cur_reg.s1;
        cur_next.s3 = cur_reg.s2;
        for (int i = 0; i < 5; i++) begin
            if (cur_reg.s2[i] == cur_reg.s3[i]) begin
                cur_next.filt[i] = cur_reg.s3[i];
            end
        end

        // control tick divider
        cur_next.tick = 1'b0;
        if (cur_reg.tick_cnt == TICK_LAST) begin
            cur_next.tick_cnt = 10'h000;
            cur_next.tick     = 1'b1;
        end else begin
            cur_next.tick_cnt = cur_reg.tick_cnt + 10'h001;
        end

        // ****************************************
        // apb slave: one wait-free access phase
        // ****************************************
        cur_next.rsp.pready  = 1'b0;
        cur_next.rsp.pslverr = 1'b0;
        if (apb_req_in.psel && !apb_req_in.penable) begin
            cur_next.rsp.pready = 1'b1;
            unique case (apb_req_in.paddr)
                `OFS_CTRL:       cur_next.rsp.prdata = cur_reg.ctrl;
                `OFS_ASSIGN:     cur_next.rsp.prdata = cur_reg.asg;
                `OFS_UP_TIMES:   cur_next.rsp.prdata = cur_reg.up_t;
                `OFS_DOWN_TIMES: cur_next.rsp.prdata = cur_reg.dn_t;
                `OFS_FREQ:       cur_next.rsp.prdata = cur_reg.fcfg;
                // bits 31:28 and 16 of status read as zero
                `OFS_STATUS:     cur_next.rsp.prdata = {4'h0, cur_reg.coast_lock,
                                     cur_reg.st, li, dc_high, cur_reg.dout.loss_braking,
                                     cur_reg.dout.motor_enable, 1'b0, cur_reg.freq};
                default: begin
                    cur_next.rsp.prdata  = 32'h0000_0000;
                    cur_next.rsp.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_req_in.psel && apb_req_in.penable && cur_reg.rsp.pready
            && apb_req_in.pwrite) begin
            unique case (apb_req_in.paddr)
                `OFS_CTRL:       cur_next.ctrl = apb_req_in.pwdata;
                `OFS_ASSIGN:     cur_next.asg  = apb_req_in.pwdata;
                `OFS_UP_TIMES:   cur_next.up_t = apb_req_in.pwdata;
                `OFS_DOWN_TIMES: cur_next.dn_t = apb_req_in.pwdata;
                `OFS_FREQ:       cur_next.fcfg = apb_req_in.pwdata;
                default:         cur_next.ctrl = cur_reg.ctrl;
            endcase
        end

        // ****************************************
        // stop sequencing
        // ****************************************
        profile   = cur_reg.ctrl[`CTRL_PROFILE_LO +: 2];
        adapt     = cur_reg.ctrl[`CTRL_ADAPT_LO +: 2];
        stop_type = cur_reg.ctrl[`CTRL_STOP_TYPE_LO +: 2];
        run_cmd   = cur_reg.ctrl[`CTRL_RUN];
        rated     = cur_reg.fcfg[15:0];
        sw_act    = li_pick(cur_reg.asg[`ASG_SWITCH_LO +: 4], li);
        coast_trig = low_pick(cur_reg.asg[`ASG_COAST_LO +: 3], li);
        quick_trig = low_pick(cur_reg.asg[`ASG_QUICK_LO +: 3], li);
        div = cur_reg.asg[`ASG_DIV_LO +: 4];
        if (div == 4'h0) begin
            div = 4'h1;
        end else if (div > `DIV_MAX) begin
            div = `DIV_MAX;
        end
        stop_req = !run_cmd || cur_reg.ctrl[`CTRL_STOP];
        cur_next.run_prev = run_cmd;

        // coast restart only for two-wire level control (two-wire and level bits both set), else fresh run
        if (coast_trig) begin
            cur_next.coast_lock = 1'b1;
        end else if (!run_cmd) begin
            cur_next.coast_lock = 1'b0;
        end else if (cur_reg.ctrl[`CTRL_TWO_WIRE] && cur_reg.ctrl[`CTRL_TRIG_LEVEL]) begin
            cur_next.coast_lock = 1'b0;
        end

        // stop kind chosen on run loss or stop command
        if (coast_trig || cur_reg.coast_lock) begin
            cur_next.st = ST_COAST;
        end else if (quick_trig) begin
            cur_next.st = ST_FAST_STOP;
        end else if (stop_req) begin
            if (cur_reg.st == ST_RUN || cur_reg.st == ST_RAMP_STOP
                || cur_reg.st == ST_FAST_STOP) begin
                unique case (stop_type)
                    2'h1:    cur_next.st = ST_FAST_STOP;
                    2'h2:    cur_next.st = ST_COAST;
                    default: cur_next.st = ST_RAMP_STOP;
                endcase
            end
            if (cur_reg.freq == 16'h0000) begin
                cur_next.st = ST_IDLE;
            end
        end else if (run_cmd && (cur_reg.st == ST_IDLE || cur_reg.st == ST_COAST
                     || !cur_reg.run_prev)) begin
            cur_next.st = ST_RUN;
        end

        // ****************************************
        // ramp generator
        // ****************************************
        target = (cur_reg.st == ST_RUN) ? cur_reg.fcfg[31:16] : 16'h0000;
        if (target > rated) begin
            target = rated;
        end
        accel = target > cur_reg.freq;
        // second ramp pair when switch active; loop start uses it for acceleration only
        if (accel) begin
            ramp_time = (sw_act || cur_reg.ctrl[`CTRL_LOOP_START])
                        ? cur_reg.up_t[31:16] : cur_reg.up_t[15:0];
        end else begin
            ramp_time = sw_act ? cur_reg.dn_t[31:16] : cur_reg.dn_t[15:0];
        end

        // S rounds both ends; U rounds the approach to target
        span  = (target > cur_reg.start) ? target - cur_reg.start : cur_reg.start - target;
        prog  = (cur_reg.freq > cur_reg.start) ? cur_reg.freq - cur_reg.start
                                               : cur_reg.start - cur_reg.freq;
        slope = `SLOPE_NOMINAL;
        unique case (profile)
            2'h1: begin
                if (20'(prog) * 20'h0000a < 20'(span) * 20'h00003
                    || 20'(prog) * 20'h0000a > 20'(span) * 20'h00007) begin
                    slope = `SLOPE_S_ROUND;
                end
            end
            2'h2: begin
                if (17'(prog) * 17'h00002 >= 17'(span)) begin
                    slope = `SLOPE_U_ROUND;
                end
            end
            default: slope = `SLOPE_NOMINAL;
        endcase

        // ticks per unit step scale with time, over rated frequency
        // a tenth of a second is 100 ms and slope 100 is a factor of one, so the hundreds cancel
        thr = 32'(ramp_time) * 32'(`TICKS_PER_MS) * 32'(slope);
        // fast stop adds divider-fold progress per tick
        sum = cur_reg.err + 33'(rated)
              * ((cur_reg.st == ST_FAST_STOP && !accel) ? 33'(div) : 33'h1);
        // hold the deceleration while the bus is high in adaptation mode 1; no hold otherwise
        hold = !accel && adapt == 2'h1 && dc_high;

        // freewheel drops the reference in the cycle the enable falls
        if (cur_next.st == ST_COAST) begin
            cur_next.freq  = 16'h0000;
            cur_next.start = 16'h0000;
            cur_next.err   = 33'h0;
        end else if (cur_reg.freq == target) begin
            cur_next.start = cur_reg.freq;
            cur_next.err   = 33'h0;
        end else if (thr == 32'h0 || rated == 16'h0000) begin
            cur_next.freq = target;
        end else if (cur_reg.tick && !hold) begin
            // one unit step per tick when threshold crossed
            if (sum >= 33'(thr)) begin
                // backlog capped at one step so a ramp faster than the tick cannot wrap the sum
                cur_next.err  = (sum >= 33'(thr) * 33'h2) ? 33'(thr) : sum - 33'(thr);
                cur_next.freq = accel ? cur_reg.freq + 16'h0001 : cur_reg.freq - 16'h0001;
            end else begin
                cur_next.err = sum;
            end
        end
        if ((accel && cur_reg.start > cur_reg.freq)
            || (!accel && cur_reg.start < cur_reg.freq)) begin
            cur_next.start = cur_reg.freq;
        end

        // ****************************************
        // outputs
        // ****************************************
        cur_next.dout.out_freq     = cur_next.freq;
        cur_next.dout.motor_enable = cur_next.st != ST_COAST && cur_next.st != ST_IDLE;
        // loss braking flagged while decelerating in adaptation mode 2
        // drops with the enable, so a freewheel never shows braking
        cur_next.dout.loss_braking = adapt == 2'h2 && !accel
                                     && cur_reg.freq != target && cur_next.dout.motor_enable;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cur_reg            <= '0;
            cur_reg.ctrl       <= `RST_CTRL;
            cur_reg.asg        <= `RST_ASSIGN;
            cur_reg.up_t       <= `RST_UP_TIMES;
            cur_reg.dn_t       <= `RST_DOWN_TIMES;
            cur_reg.fcfg       <= `RST_FREQ;
            cur_reg.st         <= ST_IDLE;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign apb_rsp_out = cur_reg.rsp;
    assign drive_out   = cur_reg.dout;

endmodule

// [tb/ramp_props.sv]
`timescale 1ns/1ps
module ramp_props
    import ramp_pkg::*;
(
    input wire logic                 ref_clk_in,
    input wire logic                 arst_n_in,
    input wire ramp_pkg::apb_req_s   apb_req_in,
    input wire ramp_pkg::apb_rsp_s   apb_rsp_out,
    input wire logic [3:0]           logic_input_in,
    input wire logic                 dc_bus_high_in,
    input wire ramp_pkg::drive_out_s drive_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    // ***
    // bus cycle
    // ***
    sequence setup_s;
        apb_req_in.psel && !apb_req_in.penable;
    endsequence
    sequence answer_s;
        apb_req_in.penable && apb_rsp_out.pready;
    endsequence
    ready_next_a: assert property (setup_s |=> answer_s)
        else $error("no answer one cycle after setup");
    ready_pulse_a: assert property (apb_rsp_out.pready |=> !apb_rsp_out.pready)
        else $error("pready held too long");
    ready_cause_a: assert property (apb_rsp_out.pready |-> $past(apb_req_in.psel))
        else $error("pready without request");
    err_ready_a: assert property (apb_rsp_out.pslverr |-> apb_rsp_out.pready)
        else $error("pslverr outside answer");
    bad_addr_a: assert property (setup_s ##0 apb_req_in.paddr > 8'h14
        |=> apb_rsp_out.pslverr && apb_rsp_out.prdata == 32'h0)
        else $error("unmapped address not refused");
    good_addr_a: assert property (setup_s ##0 apb_req_in.paddr[1:0] == 2'h0
        ##0 apb_req_in.paddr <= 8'h14 |=> !apb_rsp_out.pslverr)
        else $error("mapped address refused");
    // ***
    // drive output
    // ***
    stopped_zero_a:
    assert property (!drive_out.motor_enable |-> drive_out.out_freq == 16'h0)
        else $error("frequency while disabled");
    loss_enable_a:
    assert property (drive_out.loss_braking |-> drive_out.motor_enable)
        else $error("loss braking without enable");
    loss_fall_a:
    assert property (drive_out.loss_braking |-> drive_out.out_freq <= $past(drive_out.out_freq))
        else $error("speed rose while loss braking");
endmodule

// [tb/motor_contacts.sv]
`timescale 1ns/1ps
module motor_contacts
    import ramp_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic [3:0]           contact_closed_in,
    input  wire logic                 regen_in,
    input  wire ramp_pkg::drive_out_s drive_in,
    output logic [3:0]                levels_out,
    output logic                      dc_high_out
);
    logic [15:0] last_freq_reg;
    logic [7:0]  hold_reg;
    // ***
    // contacts and dc bus
    // ***
    // no brake resistor
    // regen energy lands on the bus, so only deceleration adaptation can save it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            levels_out    <= 4'hf;
            last_freq_reg <= 16'h0;
            hold_reg      <= 8'h0;
        end else begin
            levels_out    <= contact_closed_in;
            last_freq_reg <= drive_in.out_freq;
            if (regen_in && drive_in.motor_enable && drive_in.out_freq < last_freq_reg)
                hold_reg <= 8'hc8;
            else if (hold_reg != 8'h0)
                hold_reg <= hold_reg - 8'h1;
        end
    end
    // bus stays high for 200 cycles after every drop in speed while regen_in is set and the motor is enabled
    assign dc_high_out = hold_reg != 8'h0;
endmodule

// [tb/tb_speed_ramp_and_stop_control.sv]
`timescale 1ns/1ps
module tb_speed_ramp_and_stop_control;
    import ramp_pkg::*;
    logic        clk;
    logic        rst_n;
    apb_req_s    req;
    apb_rsp_s    rsp;
    drive_out_s  drv;
    logic [3:0]  lvl;
    logic [3:0]  contacts;
    logic [3:0]  m;
    logic [31:0] q;
    logic [15:0] t;
    logic        e;
    logic        dc_high;
    logic        regen;
    logic        lb_seen;
    logic        sw;
    int          fail_count;
    int          tests_run;
    int          seed;
    int          cyc;
    int          x;
    int          prof[3] = '{1000, 1400, 1500};

`define CHK(n, xp, g) begin tests_run++; if ((g) !== (xp)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", n, xp, g); end end

    speed_ramp_and_stop_control uut (.ref_clk_in(clk), .arst_n_in(rst_n), .apb_req_in(req),
        .apb_rsp_out(rsp), .logic_input_in(lvl), .dc_bus_high_in(dc_high), .drive_out(drv));
    motor_contacts far (.clk_in(clk), .rst_n_in(rst_n), .contact_closed_in(contacts),
        .regen_in(regen), .drive_in(drv), .levels_out(lvl), .dc_high_out(dc_high));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ***
    // bus and wait helpers
    // ***
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        if (rsp.pready !== 1'b1) begin
            fail_count++;
            give_verdict();
        end
    endtask

    // speed is looked at before each edge lands, so the count is in whole cycles
    task automatic ramp_to(input logic [15:0] g);
        cyc = 0;
        lb_seen = 1'b0;
        while (drv.out_freq !== g && cyc < 20000) begin
            @(posedge clk);
            cyc++;
            lb_seen = lb_seen | drv.loss_braking;
        end
        if (cyc >= 20000) begin
            fail_count++;
            give_verdict();
        end
    endtask

    function automatic logic near(int c, int xp);
        return c > xp - 100 && c < xp + 100;
    endfunction

    function automatic logic [31:0] rst_val(int i);
        case (i)
            1: return 32'h0000_4000;
            2, 3: return {16'h0032, 16'h001e};
            4: return 32'h0000_01f4;
            default: return 32'h0;
        endcase
    endfunction

    // ***
    // main sequence
    // ***
    initial begin
        req = '0;
        rst_n = 1'b0;
        contacts = 4'hf;
        regen = 1'b0;
        fail_count = 0;
        tests_run = 0;
        seed = 32'h09720162;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK("reset value", rst_val(i), q)
        end
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {e, q})
        $display("reset test done");
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0c, 32'h0);
        for (int i = 0; i < 6; i++) begin
            t = (i == 0) ? 16'hffff : 16'($random(seed)) & 16'h1fff;
            apb(1'b1, 8'h10, {t, 16'h1388});
            apb(1'b1, 8'h00, 32'h1);
            ramp_to(t > 16'h1388 ? 16'h1388 : t);
            `CHK("zero time jump", 1'b1, cyc < 20)
        end
        $display("jump test done");
        apb(1'b1, 8'h08, 32'h1);
        // rated 50000 units: a 0.1 s linear ramp over 20 units lasts 1000 clocks
        apb(1'b1, 8'h10, {16'h0014, 16'hc350});
        for (int p = 0; p < 3; p++) begin
            apb(1'b1, 8'h00, 32'h0);
            ramp_to(16'h0);
            apb(1'b1, 8'h00, 32'(1 + 4 * p));
            ramp_to(16'h0014);
            `CHK("profile time", 1'b1, near(cyc, prof[p]))
        end
        apb(1'b1, 8'h00, 32'h0);
        ramp_to(16'h0);
        $display("profile test done");
        apb(1'b1, 8'h08, 32'h0002_0001);
        apb(1'b1, 8'h0c, 32'h0002_0001);
        for (int c = 0; c < 9; c++) begin
            sw = 1'($random(seed));
            m = 4'h1 << ((c + 3) % 4);
            contacts <= ((c < 5) == sw) ? m : ~m;
            apb(1'b1, 8'h04, 32'h4000 | c);
            x = (sw && c > 0) ? 2000 : 1000;
            apb(1'b1, 8'h00, 32'h1);
            ramp_to(16'h0014);
            `CHK("up time", 1'b1, near(cyc, x))
            apb(1'b1, 8'h00, 32'h0);
            ramp_to(16'h0);
            `CHK("down time", 1'b1, near(cyc, x))
        end
        apb(1'b1, 8'h04, 32'h4000);
        apb(1'b1, 8'h00, 32'h401);
        ramp_to(16'h0014);
        `CHK("loop start up", 1'b1, near(cyc, 2000))
        apb(1'b1, 8'h00, 32'h400);
        ramp_to(16'h0);
        `CHK("loop start down", 1'b1, near(cyc, 1000))
        $display("ramp pair test done");
        contacts <= 4'hf;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0c, 32'h000a);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h04, k ? 32'h0000_5000 : 32'h0000_a100);
            apb(1'b1, 8'h00, 32'h41);
            ramp_to(16'h0014);
            if (k) apb(1'b1, 8'h00, 32'h40);
            else contacts[0] <= 1'b0;
            ramp_to(16'h0);
            `CHK("quick stop", 1'b1, near(cyc, 1000 * (k + 1)))
            contacts <= 4'hf;
            // a held run does not restart after a quick stop, so drop it first
            apb(1'b1, 8'h00, 32'h0);
        end
        $display("quick stop test done");
        apb(1'b1, 8'h04, 32'h0000_4020);
        apb(1'b1, 8'h00, 32'h1);
        ramp_to(16'h0014);
        contacts[1] <= 1'b0;
        ramp_to(16'h0);
        `CHK("coast time", 1'b1, cyc < 12)
        `CHK("coast enable", 1'b0, drv.motor_enable)
        contacts[1] <= 1'b1;
        repeat (200) @(posedge clk);
        `CHK("coast lock", 16'h0, drv.out_freq)
        apb(1'b1, 8'h00, 32'h301);
        ramp_to(16'h0014);
        `CHK("coast release", 1'b1, cyc < 50)
        $display("freewheel test done");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h0000_4000);
        apb(1'b1, 8'h0c, 32'h1);
        regen <= 1'b1;
        for (int a = 0; a < 3; a++) begin
            apb(1'b1, 8'h00, 32'(1 + 16 * a));
            ramp_to(16'h0014);
            apb(1'b1, 8'h00, 32'(16 * a));
            ramp_to(16'h0);
            `CHK("decel", 1'b1, a == 1 ? cyc > 1500 : near(cyc, 1000))
            `CHK("loss flag", a == 2, lb_seen)
        end
        $display("adaptation test done");
        give_verdict();
    end
endmodule

bind speed_ramp_and_stop_control ramp_props chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out), .logic_input_in(logic_input_in),
    .dc_bus_high_in(dc_bus_high_in), .drive_out(drive_out));
